// ===== design/scc_params.svh
// Offsets, field positions, reset values and fixed addresses of the system control coprocessor
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// Register numbers
`define SCC_REG_INSTR_SPACE_BASE 5'h00
`define SCC_REG_INSTR_SPACE_BOUND 5'h01
`define SCC_REG_DATA_SPACE_BASE 5'h02
`define SCC_REG_DATA_SPACE_BOUND 5'h03
`define SCC_REG_FAULTING_VADDR 5'h08
`define SCC_REG_CYCLE_COUNT 5'h09
`define SCC_REG_TIMER_COMPARE 5'h0b
`define SCC_REG_PROCESSOR_STATUS 5'h0c
`define SCC_REG_EXCEPTION_CAUSE 5'h0d
`define SCC_REG_EXCEPTION_RETURN_PC 5'h0e
`define SCC_REG_PROCESSOR_IDENTITY 5'h0f
`define SCC_REG_CACHE_SYSTEM_ATTR 5'h10
`define SCC_REG_REGION_CACHE_ALG 5'h11
`define SCC_REG_INSTR_WATCH 5'h12
`define SCC_REG_DATA_WATCH 5'h13
`define SCC_REG_EVENT_STATUS 5'h14
`define SCC_REG_EVENT_MASK 5'h15
`define SCC_REG_CACHE_DIAG_CHECK 5'h1a
`define SCC_REG_CACHE_FAULT_INFO 5'h1b
`define SCC_REG_CACHE_TAG_LOW 5'h1c
`define SCC_REG_CACHE_FAULT_RET_PC 5'h1e

// Processor status fields
`define SCC_ST_INT_ENABLE 0
`define SCC_ST_EXC_LEVEL 1
`define SCC_ST_USER_MODE 4
`define SCC_ST_WATCH_ENABLE 21
`define SCC_ST_INT_VECTOR 22
`define SCC_ST_CP1_ENABLE 28
`define SCC_ST_USER_CP0 29
`define SCC_STATUS_RESET 32'h0000_0000

// Exception cause fields
`define SCC_CAUSE_CODE_LSB 2
`define SCC_CAUSE_SOFT_LSB 8
`define SCC_CAUSE_TIMER_BIT 15

// Event bits of the sticky status and mask registers
`define SCC_EV_TIMER 0
`define SCC_EV_ADDR_FAULT 1
`define SCC_EV_WATCH 2
`define SCC_EV_COUNT 3

// Segment boundaries and fixed mapping
`define SCC_CACHED_KSEG_START 32'h8000_0000
`define SCC_UNCACHED_KSEG_START 32'ha000_0000
`define SCC_UPPER_KSEG_START 32'hc000_0000
`define SCC_KSEG_PHYS_MASK 32'h1fff_ffff
`define SCC_CACHE_ATTR_UNCACHED 4'h2

// Exception vectors and identity value (arbitrary)
`define SCC_GENERAL_VECTOR 32'h8000_0100
`define SCC_INTERRUPT_VECTOR 32'h8000_0200
`define SCC_IDENTITY_VALUE 32'h0000_5a01
`define SCC_WORD_RESET 32'h0000_0000

`endif

// ===== design/scc_pkg.sv
// Types shared by the system control coprocessor and its partners
package scc_pkg;

    // Kind of pipeline access
    typedef enum logic [1:0] {SCC_FETCH, SCC_LOAD, SCC_STORE} scc_kind_type;

    // Access presented by the pipeline
    typedef struct packed {
        logic valid;
        scc_kind_type kind;
        logic [31:0] vaddr;
    } scc_access_type;

    // Translation answer
    typedef struct packed {
        logic valid;
        logic fault;
        logic watch;
        logic [3:0] cache_attr;
        logic [31:0] paddr;
    } scc_result_type;

    // Exception entry reported by the pipeline
    typedef struct packed {
        logic take;
        logic is_int;
        logic [4:0] code;
        logic [31:0] pc;
    } scc_exc_type;

endpackage : scc_pkg

// ===== design/scc_top.sv
// System control coprocessor: privileged registers, modes, base-bounds translation, timer, watch
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "scc_params.svh"

module scc_top
    import scc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [4:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_denied,
    input wire scc_access_type i_access,
    output scc_result_type o_result,
    input wire scc_exc_type i_exc,
    input wire logic i_exc_return,
    output logic [31:0] o_exc_vector,
    output logic o_kernel_mode,
    output logic o_cp1_enable,
    output logic o_irq
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [31:0] instr_space_base;
    logic [31:0] instr_space_bound;
    logic [31:0] data_space_base;
    logic [31:0] data_space_bound;
    logic [31:0] faulting_virtual_address;
    logic [31:0] cycle_count;
    logic [31:0] timer_compare;
    logic [31:0] processor_status;
    logic [4:0] cause_code;
    logic [1:0] cause_soft;
    logic [31:0] exception_return_pc;
    logic [31:0] cache_system_attributes;
    logic [31:0] region_cache_algorithm;
    logic [31:0] instr_watch_address;
    logic [31:0] data_watch_address;
    logic [31:0] cache_diag_check_bits;
    logic [31:0] cache_tag_low;
    logic [31:0] cache_fault_return_pc;
    logic [`SCC_EV_COUNT-1:0] event_status;
    logic [`SCC_EV_COUNT-1:0] event_mask;
    logic count_phase;

    // ------------------------------------------------------------
    // Mode and privilege
    // ------------------------------------------------------------
    // Kernel whenever the user bit is clear or an exception is in service
    wire kernel_mode = ~processor_status[`SCC_ST_USER_MODE] | processor_status[`SCC_ST_EXC_LEVEL];
    wire reg_allowed = kernel_mode | processor_status[`SCC_ST_USER_CP0];
    wire wr_ok = i_reg_write & reg_allowed;
    wire rd_ok = i_reg_read & reg_allowed;
    wire next_denied = (i_reg_write | i_reg_read) & ~reg_allowed;

    // Write decode, one enable per writable number
    wire wr_instr_space_base = wr_ok & (i_reg_addr == `SCC_REG_INSTR_SPACE_BASE);
    wire wr_instr_space_bound = wr_ok & (i_reg_addr == `SCC_REG_INSTR_SPACE_BOUND);
    wire wr_data_space_base = wr_ok & (i_reg_addr == `SCC_REG_DATA_SPACE_BASE);
    wire wr_data_space_bound = wr_ok & (i_reg_addr == `SCC_REG_DATA_SPACE_BOUND);
    wire wr_count = wr_ok & (i_reg_addr == `SCC_REG_CYCLE_COUNT);
    wire wr_compare = wr_ok & (i_reg_addr == `SCC_REG_TIMER_COMPARE);
    wire wr_status = wr_ok & (i_reg_addr == `SCC_REG_PROCESSOR_STATUS);
    wire wr_cause = wr_ok & (i_reg_addr == `SCC_REG_EXCEPTION_CAUSE);
    wire wr_epc = wr_ok & (i_reg_addr == `SCC_REG_EXCEPTION_RETURN_PC);
    wire wr_config = wr_ok & (i_reg_addr == `SCC_REG_CACHE_SYSTEM_ATTR);
    wire wr_region_cache_algorithm = wr_ok & (i_reg_addr == `SCC_REG_REGION_CACHE_ALG);
    wire wr_instr_watch_address = wr_ok & (i_reg_addr == `SCC_REG_INSTR_WATCH);
    wire wr_data_watch_address = wr_ok & (i_reg_addr == `SCC_REG_DATA_WATCH);
    wire wr_evstat = wr_ok & (i_reg_addr == `SCC_REG_EVENT_STATUS);
    wire wr_evmask = wr_ok & (i_reg_addr == `SCC_REG_EVENT_MASK);
    wire wr_ecc = wr_ok & (i_reg_addr == `SCC_REG_CACHE_DIAG_CHECK);
    wire wr_cache_tag_low = wr_ok & (i_reg_addr == `SCC_REG_CACHE_TAG_LOW);
    wire wr_errpc = wr_ok & (i_reg_addr == `SCC_REG_CACHE_FAULT_RET_PC);

    // ------------------------------------------------------------
    // Timer
    // ------------------------------------------------------------
    // half rate tick
    wire count_tick = count_phase;
    wire [31:0] next_count = wr_count ? i_reg_wdata : (count_tick ? cycle_count + 32'h0000_0001 : cycle_count);
    wire timer_event = (next_count != cycle_count) & (next_count == timer_compare);

    // ------------------------------------------------------------
    // Address translation
    // ------------------------------------------------------------
    wire [31:0] vaddr = i_access.vaddr;
    wire is_fetch = (i_access.kind == SCC_FETCH);
    wire in_user_seg = (vaddr < `SCC_CACHED_KSEG_START);
    wire in_uncached_seg = (vaddr >= `SCC_UNCACHED_KSEG_START) & (vaddr < `SCC_UPPER_KSEG_START);
    wire in_upper_seg = (vaddr >= `SCC_UPPER_KSEG_START);
    wire [31:0] sel_base = is_fetch ? instr_space_base : data_space_base;
    wire [31:0] sel_bound = is_fetch ? instr_space_bound : data_space_bound;
    wire in_bound = (vaddr <= sel_bound);
    wire user_access = ~kernel_mode;
    wire seg_fault = user_access & ~in_user_seg;
    wire bound_fault = user_access & in_user_seg & ~in_bound;
    wire addr_fault = i_access.valid & (seg_fault | bound_fault);
    wire [31:0] user_paddr = vaddr + sel_base;
    wire [31:0] kernel_paddr = (in_upper_seg | in_user_seg) ? vaddr : (vaddr & `SCC_KSEG_PHYS_MASK);
    wire [31:0] next_paddr = addr_fault ? `SCC_WORD_RESET : (user_access ? user_paddr : kernel_paddr);
    wire [2:0] region = vaddr[31:29];
    wire [3:0] region_attr = region_cache_algorithm[{region, 2'b00} +: 4];
    wire [3:0] next_attr = in_uncached_seg ? `SCC_CACHE_ATTR_UNCACHED : region_attr;
    wire instr_watch_address_hit = is_fetch & (vaddr[31:2] == instr_watch_address[31:2]);
    wire data_watch_address_hit = ~is_fetch & (vaddr[31:2] == data_watch_address[31:2]);
    wire watch_hit = i_access.valid & ~addr_fault & processor_status[`SCC_ST_WATCH_ENABLE]
        & (instr_watch_address_hit | data_watch_address_hit);

    // ------------------------------------------------------------
    // Event flags and interrupt
    // ------------------------------------------------------------
    wire [`SCC_EV_COUNT-1:0] event_in;
    assign event_in[`SCC_EV_TIMER] = timer_event;
    assign event_in[`SCC_EV_ADDR_FAULT] = addr_fault;
    assign event_in[`SCC_EV_WATCH] = watch_hit;
    wire [`SCC_EV_COUNT-1:0] next_event_status;

    // Set beats a same-cycle write-one-to-clear, so no event is lost
    genvar ev;
    generate
        for (ev = 0; ev < `SCC_EV_COUNT; ev++)
        begin : g_event
            assign next_event_status[ev] = event_in[ev] | (event_status[ev] & ~(wr_evstat & i_reg_wdata[ev]));
        end
    endgenerate

    wire next_irq = |(event_status & event_mask);

    // ------------------------------------------------------------
    // Exception entry and vector
    // ------------------------------------------------------------
    // separate interrupt vector
    wire use_int_vector = i_exc.is_int & processor_status[`SCC_ST_INT_VECTOR];
    wire [31:0] next_vector = use_int_vector ? `SCC_INTERRUPT_VECTOR : `SCC_GENERAL_VECTOR;
    wire [31:0] status_sw = wr_status ? i_reg_wdata : processor_status;
    wire [31:0] next_status = i_exc.take ? (status_sw | (32'h0000_0001 << `SCC_ST_EXC_LEVEL))
        : (i_exc_return ? (status_sw & ~(32'h0000_0001 << `SCC_ST_EXC_LEVEL)) : status_sw);

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    wire [31:0] cause_value = ({31'h0000_0000, event_status[`SCC_EV_TIMER]} << `SCC_CAUSE_TIMER_BIT)
        | ({30'h0000_0000, cause_soft} << `SCC_CAUSE_SOFT_LSB)
        | ({27'h0000_0000, cause_code} << `SCC_CAUSE_CODE_LSB);
    logic [31:0] read_value;

    always_comb
    begin
        read_value = `SCC_WORD_RESET;
        case (i_reg_addr)
            `SCC_REG_INSTR_SPACE_BASE: read_value = instr_space_base;
            `SCC_REG_INSTR_SPACE_BOUND: read_value = instr_space_bound;
            `SCC_REG_DATA_SPACE_BASE: read_value = data_space_base;
            `SCC_REG_DATA_SPACE_BOUND: read_value = data_space_bound;
            `SCC_REG_FAULTING_VADDR: read_value = faulting_virtual_address;
            `SCC_REG_CYCLE_COUNT: read_value = cycle_count;
            `SCC_REG_TIMER_COMPARE: read_value = timer_compare;
            `SCC_REG_PROCESSOR_STATUS: read_value = processor_status;
            `SCC_REG_EXCEPTION_CAUSE: read_value = cause_value;
            `SCC_REG_EXCEPTION_RETURN_PC: read_value = exception_return_pc;
            `SCC_REG_PROCESSOR_IDENTITY: read_value = `SCC_IDENTITY_VALUE;
            `SCC_REG_CACHE_SYSTEM_ATTR: read_value = cache_system_attributes;
            `SCC_REG_REGION_CACHE_ALG: read_value = region_cache_algorithm;
            `SCC_REG_INSTR_WATCH: read_value = instr_watch_address;
            `SCC_REG_DATA_WATCH: read_value = data_watch_address;
            `SCC_REG_EVENT_STATUS: read_value = {29'h0000_0000, event_status};
            `SCC_REG_EVENT_MASK: read_value = {29'h0000_0000, event_mask};
            `SCC_REG_CACHE_DIAG_CHECK: read_value = cache_diag_check_bits;
            `SCC_REG_CACHE_FAULT_INFO: read_value = `SCC_WORD_RESET;
            `SCC_REG_CACHE_TAG_LOW: read_value = cache_tag_low;
            `SCC_REG_CACHE_FAULT_RET_PC: read_value = cache_fault_return_pc;
            default: read_value = `SCC_WORD_RESET;
        endcase
    end

    // ------------------------------------------------------------
    // Register bus answer
    // ------------------------------------------------------------
    // Data only in the cycle after the read strobe, zero otherwise
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_reg_rdata <= `SCC_WORD_RESET;
            o_reg_denied <= 1'b0;
        end
        else
        begin
            o_reg_rdata <= rd_ok ? read_value : `SCC_WORD_RESET;
            o_reg_denied <= next_denied;
        end
    end

    // ------------------------------------------------------------
    // Translation, watch and diagnostic registers
    // ------------------------------------------------------------
    // only decoded numbers store
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            instr_space_base <= `SCC_WORD_RESET;
            instr_space_bound <= `SCC_WORD_RESET;
            data_space_base <= `SCC_WORD_RESET;
            data_space_bound <= `SCC_WORD_RESET;
            region_cache_algorithm <= `SCC_WORD_RESET;
            instr_watch_address <= `SCC_WORD_RESET;
            data_watch_address <= `SCC_WORD_RESET;
            cache_system_attributes <= `SCC_WORD_RESET;
            cache_diag_check_bits <= `SCC_WORD_RESET;
            cache_tag_low <= `SCC_WORD_RESET;
            cache_fault_return_pc <= `SCC_WORD_RESET;
        end
        else
        begin
            if (wr_instr_space_base) instr_space_base <= i_reg_wdata;
            if (wr_instr_space_bound) instr_space_bound <= i_reg_wdata;
            if (wr_data_space_base) data_space_base <= i_reg_wdata;
            if (wr_data_space_bound) data_space_bound <= i_reg_wdata;
            if (wr_region_cache_algorithm) region_cache_algorithm <= i_reg_wdata;
            if (wr_instr_watch_address) instr_watch_address <= i_reg_wdata;
            if (wr_data_watch_address) data_watch_address <= i_reg_wdata;
            if (wr_config) cache_system_attributes <= i_reg_wdata; // Plain storage; cache logic lives elsewhere
            if (wr_ecc) cache_diag_check_bits <= i_reg_wdata;
            if (wr_cache_tag_low) cache_tag_low <= i_reg_wdata;
            if (wr_errpc) cache_fault_return_pc <= i_reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Timer registers
    // ------------------------------------------------------------
    // phase toggles every cycle, a count write clears it
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            cycle_count <= `SCC_WORD_RESET;
            count_phase <= 1'b0;
            timer_compare <= `SCC_WORD_RESET;
        end
        else
        begin
            cycle_count <= next_count;
            count_phase <= wr_count ? 1'b0 : ~count_phase;
            if (wr_compare) timer_compare <= i_reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Status, cause and exception state
    // ------------------------------------------------------------
    // reset lands in kernel
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            processor_status <= `SCC_STATUS_RESET;
            cause_code <= 5'h00;
            cause_soft <= 2'h0;
            exception_return_pc <= `SCC_WORD_RESET;
            o_exc_vector <= `SCC_GENERAL_VECTOR;
        end
        else
        begin
            processor_status <= next_status;
            if (wr_cause) cause_soft <= i_reg_wdata[`SCC_CAUSE_SOFT_LSB +: 2];
            if (i_exc.take)
            begin
                cause_code <= i_exc.code;
                exception_return_pc <= i_exc.pc;
                o_exc_vector <= next_vector;
            end
            else if (wr_epc)
            begin
                exception_return_pc <= i_reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Access answer and fault capture
    // ------------------------------------------------------------
    // capture bad address
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            faulting_virtual_address <= `SCC_WORD_RESET;
            o_result <= '0;
        end
        else
        begin
            if (addr_fault) faulting_virtual_address <= vaddr;
            o_result.valid <= i_access.valid;
            o_result.fault <= addr_fault;
            o_result.watch <= watch_hit;
            o_result.cache_attr <= i_access.valid ? next_attr : 4'h0;
            o_result.paddr <= i_access.valid ? next_paddr : `SCC_WORD_RESET;
        end
    end

    // ------------------------------------------------------------
    // Events, mask and mode outputs
    // ------------------------------------------------------------
    // Outputs registered so the pipeline sees stable levels
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            event_status <= '0;
            event_mask <= '0;
            o_irq <= 1'b0;
            o_kernel_mode <= 1'b1;
            o_cp1_enable <= 1'b0;
        end
        else
        begin
            event_status <= next_event_status;
            if (wr_evmask) event_mask <= i_reg_wdata[`SCC_EV_COUNT-1:0];
            o_irq <= next_irq;
            o_kernel_mode <= ~next_status[`SCC_ST_USER_MODE] | next_status[`SCC_ST_EXC_LEVEL];
            o_cp1_enable <= next_status[`SCC_ST_CP1_ENABLE];
        end
    end

endmodule : scc_top

// ===== tb/scc_top_chk.sv
// Port checker for the system control coprocessor
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_chk
    import scc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_reg_read,
    input wire logic [31:0] o_reg_rdata,
    input wire scc_access_type i_access,
    input wire scc_result_type o_result,
    input wire scc_exc_type i_exc,
    input wire logic [31:0] o_exc_vector,
    input wire logic o_kernel_mode
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // ----------------
    // Properties
    // ----------------
    sequence s_user_high;
        i_access.valid && !o_kernel_mode && i_access.vaddr[31];
    endsequence
    sequence s_kern_seg;
        i_access.valid && o_kernel_mode && i_access.vaddr[31:30] == 2'b10;
    endsequence
    property p_read_idle; !$past(i_reg_read) |-> o_reg_rdata == 32'h0; endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");
    property p_result_lag; i_access.valid |=> o_result.valid; endproperty
    a_result_lag: assert property (p_result_lag) else $error("no result after access");
    property p_fault_clear; o_result.fault |-> o_result.valid && o_result.paddr == 32'h0; endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("faulted access carried out");
    property p_user_kseg; s_user_high |=> o_result.fault; endproperty
    a_user_kseg: assert property (p_user_kseg) else $error("user reached kernel segment");
    property p_kseg_fixed;
        s_kern_seg |=> !o_result.fault && o_result.paddr == ($past(i_access.vaddr) & `SCC_KSEG_PHYS_MASK);
    endproperty
    a_kseg_fixed: assert property (p_kseg_fixed) else $error("kernel segment mapping wrong");
    property p_uncached;
        i_access.valid && o_kernel_mode && i_access.vaddr[31:29] == 3'b101 |=> o_result.cache_attr == 4'h2;
    endproperty
    a_uncached: assert property (p_uncached) else $error("uncached segment attribute wrong");
    property p_exc_kernel; i_exc.take |=> o_kernel_mode; endproperty
    a_exc_kernel: assert property (p_exc_kernel) else $error("exception left user mode");
    property p_exc_general; i_exc.take && !i_exc.is_int |=> o_exc_vector == `SCC_GENERAL_VECTOR; endproperty
    a_exc_general: assert property (p_exc_general) else $error("general vector wrong");
    property p_reset_state; $fell(i_srst) |-> o_kernel_mode; endproperty
    a_reset_state: assert property (p_reset_state) else $error("not kernel after reset");
endmodule : scc_chk
bind scc_top scc_chk u_scc_chk (.i_clock, .i_srst, .i_reg_read, .o_reg_rdata, .i_access,
    .o_result, .i_exc, .o_exc_vector, .o_kernel_mode);

// ===== tb/scc_pipe_model.sv
// Integer pipeline model: presents accesses and exception entries
`timescale 1ns/1ps
module scc_pipe_model
    import scc_pkg::*;
(
    input wire logic i_clock,
    output scc_access_type o_access,
    output scc_exc_type o_exc,
    output logic o_exc_return
);
    // Idle at time zero
    initial
    begin
        o_access = '0;
        o_exc = '0;
        o_exc_return = 1'b0;
    end
    // Released address is inverted so a stale value never looks valid
    task automatic access(input scc_kind_type k, input logic [31:0] va);
        @(posedge i_clock);
        o_access <= '{1'b1, k, va};
        @(posedge i_clock);
        o_access <= '{1'b0, k, ~va};
        #1;
    endtask : access
    // Exception entry, one cycle pulse
    task automatic exc(input logic is_int, input logic [31:0] pc);
        @(posedge i_clock);
        o_exc <= '{1'b1, is_int, 5'h04, pc};
        @(posedge i_clock);
        o_exc <= '{1'b0, 1'b0, 5'h0, ~pc};
        #1;
    endtask : exc
    // Exception return pulse
    task automatic ret;
        @(posedge i_clock);
        o_exc_return <= 1'b1;
        @(posedge i_clock);
        o_exc_return <= 1'b0;
        #1;
    endtask : ret
endmodule : scc_pipe_model

// ===== tb/test_system_control_coprocessor.sv
// Self-checking bench for the system control coprocessor
`timescale 1ns/1ps
`include "scc_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module test_system_control_coprocessor
    import scc_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic [4:0] i_reg_addr = 5'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic i_reg_write = 1'b0;
    logic i_reg_read = 1'b0;
    logic [31:0] o_reg_rdata, o_exc_vector;
    logic o_reg_denied, o_kernel_mode, o_cp1_enable, o_irq, i_exc_return;
    scc_access_type i_access;
    scc_result_type o_result;
    scc_exc_type i_exc;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    // ----------------
    // Harness
    // ----------------
    always #2.5 i_clock = ~i_clock;
    scc_top u_scc_top (.i_clock, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata,
        .o_reg_denied, .i_access, .o_result, .i_exc, .i_exc_return, .o_exc_vector, .o_kernel_mode,
        .o_cp1_enable, .o_irq);
    scc_pipe_model u_scc_pipe_model (.i_clock, .o_access(i_access), .o_exc(i_exc), .o_exc_return(i_exc_return));
    // Hang guard, far above the 124 or so cycles needed
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            final_report;
        end
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_write <= 1'b1;
        @(posedge i_clock);
        i_reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_clock);
        i_reg_read <= 1'b0;
        #1;
        v = o_reg_rdata;
    endtask : rd
    task automatic chk_reg(input string n, input logic [4:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(n, e, v)
    endtask : chk_reg
    task automatic acc(input scc_kind_type k, input logic [31:0] va, input logic f, input logic [31:0] pa);
        u_scc_pipe_model.access(k, va);
        `CHK("fault", f, o_result.fault)
        `CHK("paddr", pa, o_result.paddr)
    endtask : acc
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_regs;
        wr(5'h00, 32'h0100_0000);
        wr(5'h01, 32'h0000_0fff);
        wr(5'h02, 32'h0200_0000);
        wr(5'h03, 32'h0000_1fff);
        wr(5'h11, 32'h7654_3210);
        wr(5'h04, 32'hffff_ffff);
        wr(5'h0f, 32'h0);
        wr(5'h0c, 32'h1000_0000);
        chk_reg("instr_space_base", 5'h00, 32'h0100_0000);
        chk_reg("instr_space_bound", 5'h01, 32'h0000_0fff);
        chk_reg("data_space_base", 5'h02, 32'h0200_0000);
        chk_reg("data_space_bound", 5'h03, 32'h0000_1fff);
        chk_reg("region_cache_algorithm", 5'h11, 32'h7654_3210);
        chk_reg("unused", 5'h04, 32'h0);
        chk_reg("ident", 5'h0f, `SCC_IDENTITY_VALUE);
        `CHK("cp1", 1'b1, o_cp1_enable)
    endtask : t_regs
    // Two reads 20 edges apart must differ by exactly 10
    task automatic t_timer;
        logic [31:0] a, b;
        rd(5'h09, a);
        repeat (18) @(posedge i_clock);
        rd(5'h09, b);
        `CHK("count step", 32'd10, b - a)
        wr(5'h15, 32'h1);
        wr(5'h0b, 32'h6);
        wr(5'h09, 32'h0);
        repeat (10) @(posedge i_clock);
        #1;
        `CHK("irq early", 1'b0, o_irq)
        repeat (6) @(posedge i_clock);
        #1;
        `CHK("irq", 1'b1, o_irq)
        chk_reg("events", 5'h14, 32'h1);
        wr(5'h14, 32'h1);
        repeat (2) @(posedge i_clock);
        #1;
        `CHK("irq cleared", 1'b0, o_irq)
    endtask : t_timer
    task automatic t_xlate;
        wr(5'h0c, 32'h2000_0010);
        acc(SCC_LOAD, 32'h0000_0100, 1'b0, 32'h0200_0100);
        acc(SCC_FETCH, 32'h0000_0100, 1'b0, 32'h0100_0100);
        acc(SCC_LOAD, 32'h0000_1fff, 1'b0, 32'h0200_1fff);
        acc(SCC_FETCH, 32'h0000_1fff, 1'b1, 32'h0);
        chk_reg("bad address", 5'h08, 32'h0000_1fff);
        acc(SCC_STORE, 32'h0000_2000, 1'b1, 32'h0);
        acc(SCC_LOAD, 32'h8000_0000, 1'b1, 32'h0);
        wr(5'h0c, 32'h0);
        acc(SCC_LOAD, 32'h8000_1234, 1'b0, 32'h0000_1234);
        `CHK("attr", 4'h4, o_result.cache_attr)
        acc(SCC_LOAD, 32'ha000_0010, 1'b0, 32'h0000_0010);
    endtask : t_xlate
    task automatic t_watch;
        wr(5'h12, 32'hffff_ffff);
        wr(5'h0c, 32'h0060_0000);
        u_scc_pipe_model.access(SCC_FETCH, 32'hffff_fffc);
        `CHK("watch fetch", 1'b1, o_result.watch)
        u_scc_pipe_model.access(SCC_LOAD, 32'hffff_fffc);
        `CHK("watch load", 1'b0, o_result.watch)
        u_scc_pipe_model.exc(1'b1, 32'h0000_0200);
        `CHK("int vector", `SCC_INTERRUPT_VECTOR, o_exc_vector)
        u_scc_pipe_model.exc(1'b0, 32'h0000_0300);
        `CHK("gen vector", `SCC_GENERAL_VECTOR, o_exc_vector)
    endtask : t_watch
    task automatic t_deny;
        logic [31:0] v;
        wr(5'h0c, 32'h0000_0010);
        rd(5'h09, v);
        `CHK("denied data", 32'h0, v)
        `CHK("denied", 1'b1, o_reg_denied)
        u_scc_pipe_model.exc(1'b0, 32'h0000_0400);
        `CHK("exc mode", 1'b1, o_kernel_mode)
        u_scc_pipe_model.ret();
        `CHK("user again", 1'b0, o_kernel_mode)
    endtask : t_deny
    initial
    begin
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        #1;
        `CHK("reset mode", 1'b1, o_kernel_mode)
        t_regs;
        t_timer;
        t_xlate;
        t_watch;
        t_deny;
        final_report;
    end
endmodule : test_system_control_coprocessor
